// File: design/hdc_host_ctl.sv
/*
 * Host controller: processor address routing, error logging with system-error
 * signalling, processor and PCI reset sequencing and slowdown mode, on APB.
 * Assumes all inputs synchronous to clk and one request per valid cycle.
 */
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module hdc_host_ctl #(
    parameter int PROC_RST_CYCLES = hdc_pkg::PROC_RESET_CYC,
    parameter int PCI_RST_CYCLES = hdc_pkg::PCI_RESET_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire hdc_pkg::hdc_cpu_req_t cpu_req,
    output hdc_pkg::hdc_route_t cpu_route,
    input wire hdc_pkg::hdc_pci_req_t pci_req,
    output logic pci_claim,
    input wire logic target_abort_rcvd,
    input wire logic pci_perr_n_in,
    input wire logic pci_parity_detect,
    input wire logic companion_error_line_n,
    input wire logic companion_error_multi,
    input wire logic [2:0] companion_error_row,
    output logic pci_serr_n_out,
    output logic pci_serr_n_oe,
    output logic pci_perr_n_out,
    output logic pci_perr_n_oe,
    output logic processor_reset_request_n,
    output logic pci_reset_output_n,
    output logic processor_init_n,
    output logic processor_flush_n,
    output logic processor_stall
);
    import hdc_pkg::*;

    function automatic logic attr_dram(input logic [1:0] a, input logic wr);
        return wr ? a[ATTR_WE] : a[ATTR_RE];
    endfunction

    hdc_state_t st;
    hdc_state_t next_st;
    logic acc;
    logic fire;
    logic wr_fire;
    logic rc_rise;
    logic hard_start;
    logic soft_start;
    logic bist_start;
    logic mb_evt;
    logic sb_evt;
    logic mb_rise;
    logic proc_rst_act;
    logic pci_rst_act;
    logic init_act;
    logic [TW-1:0] init_load;

    assign acc = psel & penable;
    assign fire = acc & st.apb_done;
    assign wr_fire = fire & pwrite;
    assign pready = st.apb_done;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;

    // Only a zero-to-one change of the trigger bit starts a reset.
    assign rc_rise = wr_fire && paddr == A_RST_CTL && pwdata[RC_TRIGGER]
        && !st.rst_ctl[RC_TRIGGER];
    assign hard_start = rc_rise & pwdata[RC_HARD];
    assign soft_start = rc_rise & ~pwdata[RC_HARD];
    assign bist_start = hard_start & pwdata[RC_SELFTEST];
    assign init_load = bist_start ? TW'(PROC_RST_CYCLES + INIT_HOLD_CYC) : TW'(SOFT_INIT_CYC);

    assign mb_evt = ~companion_error_line_n & companion_error_multi;
    assign sb_evt = ~companion_error_line_n & ~companion_error_multi;
    assign mb_rise = mb_evt & ~st.err_sts[STS_MFLAG];

    hdc_pulse_timer u_proc_rst (
        .clk(clk),
        .rst_n(rst_n),
        .start(hard_start),
        .load(TW'(PROC_RST_CYCLES)),
        .active(proc_rst_act)
    );

    hdc_pulse_timer u_pci_rst (
        .clk(clk),
        .rst_n(rst_n),
        .start(hard_start),
        .load(TW'(PCI_RST_CYCLES)),
        .active(pci_rst_act)
    );

    // With self-test the init pulse outlasts the processor reset, so it is seen at release.
    hdc_pulse_timer u_init (
        .clk(clk),
        .rst_n(rst_n),
        .start(soft_start | bist_start),
        .load(init_load),
        .active(init_act)
    );

    always_comb begin
        logic [35:0] a;
        logic to_dram;
        logic win_ok;
        logic [1:0] hsel;
        logic [7:0] w;
        logic [7:0] clr;
        a = cpu_req.addr;
        to_dram = 1'b0;
        win_ok = 1'b0;
        hsel = st.hole[HOLE_LSB +: 2];
        w = pwdata[7:0];
        clr = (wr_fire && paddr == A_ERR_STS) ? w : 8'h00;
        next_st = st;

        // Register bus: one wait state, read data and error latched for the ready cycle.
        next_st.apb_done = acc & ~st.apb_done;
        if (acc & ~st.apb_done) begin
            next_st.slverr = 1'b0;
            unique case (paddr)
                A_ERR_EN: next_st.rdata = {24'h000000, st.err_en};
                A_ERR_STS: next_st.rdata = {24'h000000, st.err_sts};
                A_RST_CTL: next_st.rdata = {24'h000000, st.rst_ctl};
                A_HOLE: next_st.rdata = {24'h000000, st.hole};
                A_WINDOW: next_st.rdata = {24'h000000, st.window};
                A_PCI_CMD: next_st.rdata = {30'h00000000, st.pci_cmd};
                A_ATTR: next_st.rdata = {6'h00, st.attr};
                A_SLOW_CNT: next_st.rdata = {24'h000000, st.slow_cnt};
                A_TOP_DRAM: next_st.rdata = {24'h000000, st.top_of_dram};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.slverr = 1'b1;
                end
            endcase
        end

        if (wr_fire) begin
            unique case (paddr)
                A_ERR_EN: next_st.err_en = w & ERR_EN_MASK;
                A_RST_CTL: next_st.rst_ctl = w & RST_CTL_MASK;
                A_HOLE: next_st.hole = w & HOLE_MASK;
                A_PCI_CMD: next_st.pci_cmd = pwdata[1:0];
                A_ATTR: next_st.attr = pwdata[ATTR_W-1:0];
                A_SLOW_CNT: next_st.slow_cnt = w;
                A_TOP_DRAM: next_st.top_of_dram = w;
                A_WINDOW: begin
                    next_st.window = w & 8'h7F;
                    if (st.window[WIN_LOCK] | w[WIN_LOCK]) begin
                        next_st.window[WIN_LOCK] = 1'b1;
                        next_st.window[WIN_OPEN] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // A new error wins over a clear written in the same cycle.
        if (mb_evt) begin
            next_st.err_sts[STS_MFLAG] = 1'b1;
            if (!st.err_sts[STS_MFLAG]) begin
                next_st.err_sts[STS_MROW +: 3] = companion_error_row;
            end
        end else if (clr[STS_MFLAG]) begin
            next_st.err_sts[STS_MFLAG] = 1'b0;
        end
        if (sb_evt) begin
            next_st.err_sts[STS_SFLAG] = 1'b1;
            if (!st.err_sts[STS_SFLAG]) begin
                next_st.err_sts[STS_SROW +: 3] = companion_error_row;
            end
        end else if (clr[STS_SFLAG]) begin
            next_st.err_sts[STS_SFLAG] = 1'b0;
        end

        next_st.serr = st.pci_cmd[CMD_SERR] & (
            (st.err_en[EN_TABORT] & target_abort_rcvd)
            | (st.err_en[EN_PARITY] & ~pci_perr_n_in)
            | (st.err_en[EN_MULTI] & mb_rise)
            | (st.err_en[EN_SINGLE] & sb_evt));
        next_st.perr = st.pci_cmd[CMD_PERR] & pci_parity_detect;

        if (bist_start) begin
            next_st.bist_run = 1'b1;
        end else if (!init_act) begin
            next_st.bist_run = 1'b0;
        end

        // Stall duty is slow_cnt out of 256 cycles; zero means caches flush only.
        next_st.phase = st.phase + 8'h01;
        next_st.flush = st.rst_ctl[RC_SLOW];
        next_st.stall = st.rst_ctl[RC_SLOW] && st.phase < st.slow_cnt;

        // Protected window: close blocks data, open shows it unless locked or close is also set.
        win_ok = st.window[WIN_ENABLE] && st.window[2:0] == WIN_BASE_A0
            && (cpu_req.handler || (st.window[WIN_OPEN] && !st.window[WIN_LOCK]))
            && !(st.window[WIN_CLOSE] && st.window[WIN_OPEN] && !st.window[WIN_LOCK])
            && !(st.window[WIN_CLOSE] && !cpu_req.code);
        if (a < DOS_LOW_END) begin
            to_dram = 1'b1;
        end else if (a < DOS_END) begin
            to_dram = hsel != HOLE_LOW;
        end else if (a < VIDEO_END) begin
            to_dram = win_ok;
        end else if (a < EXP_END) begin
            to_dram = attr_dram(st.attr[{a[16:14], 1'b0} +: 2], cpu_req.write);
        end else if (a < EXTB_END) begin
            to_dram = attr_dram(st.attr[ATTR_EXTB + {a[15:14], 1'b0} +: 2], cpu_req.write);
        end else if (a < ONE_MB) begin
            to_dram = attr_dram(st.attr[ATTR_SYS +: 2], cpu_req.write);
        end else if (hsel == HOLE_HIGH && a[31:20] == HIGH_HOLE_MB) begin
            to_dram = 1'b0;
        end else begin
            to_dram = a[31:TOM_LSB] < {1'b0, st.top_of_dram};
        end
        next_st.route.valid = cpu_req.valid;
        next_st.route.zero = cpu_req.valid && a[35:32] != 4'h0;
        next_st.route.dram = cpu_req.valid && a[35:32] == 4'h0 && to_dram;
        next_st.route.pci = cpu_req.valid && a[35:32] == 4'h0 && !to_dram;

        // PCI masters reach only plain DRAM, never holes, the window or the upper ranges.
        next_st.pci_claim = pci_req.valid && (
            (pci_req.addr < DOS_END[31:0]
                && !(hsel == HOLE_LOW && pci_req.addr >= DOS_LOW_END[31:0]))
            || (pci_req.addr >= ONE_MB[31:0]
                && pci_req.addr[31:TOM_LSB] < {1'b0, st.top_of_dram}
                && !(hsel == HOLE_HIGH && pci_req.addr[31:20] == HIGH_HOLE_MB)));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.window <= WINDOW_RST;
            st.top_of_dram <= TOP_DRAM_RST;
        end else begin
            st <= next_st;
        end
    end

    assign cpu_route = st.route;
    assign pci_claim = st.pci_claim;
    assign pci_serr_n_out = 1'b0;
    assign pci_serr_n_oe = st.serr;
    assign pci_perr_n_out = 1'b0;
    assign pci_perr_n_oe = st.perr;
    assign processor_reset_request_n = ~proc_rst_act;
    assign pci_reset_output_n = ~pci_rst_act;
    assign processor_init_n = ~init_act;
    assign processor_flush_n = ~st.flush;
    assign processor_stall = st.stall;

    logic [TW-1:0] low_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= '0;
        end else if (processor_reset_request_n) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + TW'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_tabort;
        target_abort_rcvd && st.err_en[EN_TABORT] && st.pci_cmd[CMD_SERR] |=> pci_serr_n_oe;
    endproperty
    a_tabort: assert property (p_tabort)
        else $error("target abort did not raise system error");

    property p_parity;
        !pci_perr_n_in && st.err_en[EN_PARITY] && st.pci_cmd[CMD_SERR] |=> pci_serr_n_oe;
    endproperty
    a_parity: assert property (p_parity)
        else $error("bus parity error did not raise system error");

    property p_single;
        sb_evt && st.err_en[EN_SINGLE] && st.pci_cmd[CMD_SERR] |=> pci_serr_n_oe;
    endproperty
    a_single: assert property (p_single)
        else $error("single-bit error did not raise system error");

    property p_gate;
        !st.pci_cmd[CMD_SERR] |=> !pci_serr_n_oe;
    endproperty
    a_gate: assert property (p_gate)
        else $error("system error driven while disabled");

    property p_mb_rise;
        $rose(st.err_sts[STS_MFLAG]) && $past(st.err_en[EN_MULTI] && st.pci_cmd[CMD_SERR])
            |-> pci_serr_n_oe;
    endproperty
    a_mb_rise: assert property (p_mb_rise)
        else $error("multi-bit flag rose without system error");

    property p_mb_freeze;
        st.err_sts[STS_MFLAG] ##1 st.err_sts[STS_MFLAG] |-> $stable(st.err_sts[7:5]);
    endproperty
    a_mb_freeze: assert property (p_mb_freeze)
        else $error("multi-bit row changed while flag set");

    property p_mb_w0;
        wr_fire && paddr == A_ERR_STS && !pwdata[STS_MFLAG] && st.err_sts[STS_MFLAG]
            |=> st.err_sts[STS_MFLAG];
    endproperty
    a_mb_w0: assert property (p_mb_w0)
        else $error("writing zero cleared the multi-bit flag");

    property p_hard;
        hard_start |=> !processor_reset_request_n && !pci_reset_output_n;
    endproperty
    a_hard: assert property (p_hard)
        else $error("hard reset did not assert both resets");

    property p_proc_len;
        $rose(processor_reset_request_n) |-> low_cnt == TW'(PROC_RST_CYCLES);
    endproperty
    a_proc_len: assert property (p_proc_len)
        else $error("processor reset length wrong");

    property p_soft;
        soft_start && !proc_rst_act |=> !processor_init_n && processor_reset_request_n;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset did not assert init alone");

    property p_bist;
        $rose(processor_reset_request_n) && st.bist_run |-> !processor_init_n;
    endproperty
    a_bist: assert property (p_bist)
        else $error("init not held at processor reset release");

    property p_zero;
        cpu_req.valid && cpu_req.addr[35:32] != 4'h0 |=> cpu_route.zero && !cpu_route.pci;
    endproperty
    a_zero: assert property (p_zero)
        else $error("access above 4 GB not claimed");

    property p_dos;
        cpu_req.valid && cpu_req.addr < DOS_LOW_END |=> cpu_route.dram;
    endproperty
    a_dos: assert property (p_dos)
        else $error("low DOS access not routed to DRAM");

    property p_lock;
        st.window[WIN_LOCK] |=> st.window[WIN_LOCK] && !st.window[WIN_OPEN];
    endproperty
    a_lock: assert property (p_lock)
        else $error("window lock released or open set");

    c_hard: cover property (hard_start ##1 !processor_reset_request_n);
    c_soft: cover property (soft_start ##1 !processor_init_n);
    c_mb: cover property (mb_rise ##1 pci_serr_n_oe);
    c_window: cover property (cpu_req.valid && cpu_req.handler ##1 cpu_route.dram);
endmodule

// File: inc/hdc_pkg.sv
/*
 * Shared constants and types of the host decode, error and reset controller.
 * Assumes a 100 MHz host clock and APB register access with one word per register.
 */
package hdc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int PROC_RESET_US = 2000;
    localparam int PCI_RESET_US = 1000;
    localparam int PROC_RESET_CYC = PROC_RESET_US * (CLK_HZ / 1_000_000);
    localparam int PCI_RESET_CYC = PCI_RESET_US * (CLK_HZ / 1_000_000);
    localparam int SOFT_INIT_CYC = 16;
    localparam int INIT_HOLD_CYC = 8;
    localparam int TW = 18;

    localparam logic [7:0] IDX_HOLE = 8'h68;
    localparam logic [7:0] IDX_WINDOW = 8'h72;
    localparam logic [7:0] IDX_ERR_EN = 8'h90;
    localparam logic [7:0] IDX_ERR_STS = 8'h91;
    localparam logic [7:0] IDX_RST_CTL = 8'h93;
    localparam logic [11:0] A_HOLE = {2'h0, IDX_HOLE, 2'h0};
    localparam logic [11:0] A_WINDOW = {2'h0, IDX_WINDOW, 2'h0};
    localparam logic [11:0] A_ERR_EN = {2'h0, IDX_ERR_EN, 2'h0};
    localparam logic [11:0] A_ERR_STS = {2'h0, IDX_ERR_STS, 2'h0};
    localparam logic [11:0] A_RST_CTL = {2'h0, IDX_RST_CTL, 2'h0};
    localparam logic [11:0] A_PCI_CMD = 12'h300;
    localparam logic [11:0] A_ATTR = 12'h304;
    localparam logic [11:0] A_SLOW_CNT = 12'h308;
    localparam logic [11:0] A_TOP_DRAM = 12'h30C;

    localparam int EN_TABORT = 4;
    localparam int EN_PARITY = 3;
    localparam int EN_MULTI = 1;
    localparam int EN_SINGLE = 0;
    localparam logic [7:0] ERR_EN_MASK = 8'h1B;
    localparam int STS_MROW = 5;
    localparam int STS_MFLAG = 4;
    localparam int STS_SROW = 1;
    localparam int STS_SFLAG = 0;
    localparam int RC_SELFTEST = 3;
    localparam int RC_TRIGGER = 2;
    localparam int RC_HARD = 1;
    localparam int RC_SLOW = 0;
    localparam logic [7:0] RST_CTL_MASK = 8'h0F;
    localparam int HOLE_LSB = 6;
    localparam logic [7:0] HOLE_MASK = 8'hC0;
    localparam logic [1:0] HOLE_LOW = 2'h1;
    localparam logic [1:0] HOLE_HIGH = 2'h2;
    localparam int WIN_OPEN = 6;
    localparam int WIN_CLOSE = 5;
    localparam int WIN_LOCK = 4;
    localparam int WIN_ENABLE = 3;
    localparam logic [2:0] WIN_BASE_A0 = 3'h2;
    localparam logic [7:0] WINDOW_RST = 8'h02;
    localparam int CMD_SERR = 1;
    localparam int CMD_PERR = 0;
    localparam int ATTR_W = 26;
    localparam int ATTR_EXTB = 16;
    localparam int ATTR_SYS = 24;
    localparam int ATTR_RE = 0;
    localparam int ATTR_WE = 1;
    localparam logic [7:0] TOP_DRAM_RST = 8'h01;
    localparam int TOM_LSB = 23;

    localparam logic [35:0] DOS_LOW_END = 36'h0_0008_0000;
    localparam logic [35:0] DOS_END = 36'h0_000A_0000;
    localparam logic [35:0] VIDEO_END = 36'h0_000C_0000;
    localparam logic [35:0] EXP_END = 36'h0_000E_0000;
    localparam logic [35:0] EXTB_END = 36'h0_000F_0000;
    localparam logic [35:0] ONE_MB = 36'h0_0010_0000;
    localparam logic [11:0] HIGH_HOLE_MB = 12'h00F;

    typedef struct packed {
        logic valid;
        logic [35:0] addr;
        logic write;
        logic code;
        logic handler;
    } hdc_cpu_req_t;

    typedef struct packed {
        logic valid;
        logic dram;
        logic pci;
        logic zero;
    } hdc_route_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } hdc_pci_req_t;

    typedef struct packed {
        logic active;
        logic [TW-1:0] count;
    } hdc_timer_t;

    typedef struct packed {
        logic [7:0] err_en;
        logic [7:0] err_sts;
        logic [7:0] rst_ctl;
        logic [7:0] hole;
        logic [7:0] window;
        logic [1:0] pci_cmd;
        logic [ATTR_W-1:0] attr;
        logic [7:0] slow_cnt;
        logic [7:0] top_of_dram;
        logic [7:0] phase;
        logic stall;
        logic flush;
        logic bist_run;
        logic apb_done;
        logic [31:0] rdata;
        logic slverr;
        hdc_route_t route;
        logic pci_claim;
        logic serr;
        logic perr;
    } hdc_state_t;
endpackage

// File: design/hdc_pulse_timer.sv
/*
 * Retriggerable pulse timer: output high for exactly load cycles after start.
 * Assumes load is at least one; a start while running reloads the count.
 */
`timescale 1ns/10ps
module hdc_pulse_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [hdc_pkg::TW-1:0] load,
    output logic active
);
    import hdc_pkg::*;

    hdc_timer_t st;
    hdc_timer_t next_st;

    always_comb begin
        next_st = st;
        if (start) begin
            next_st.active = 1'b1;
            next_st.count = load - TW'(1);
        end else if (st.active) begin
            if (st.count == '0) begin
                next_st.active = 1'b0;
            end else begin
                next_st.count = st.count - TW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;
endmodule

// File: test/hdc_companion_model.sv
/*
 * Model of the data-path companion chip that reports memory errors.
 * Assumes report is entered right after a rising edge of clk.
 */
`timescale 1ns/10ps
module hdc_companion_model (
    input wire logic clk,
    output logic error_line_n,
    output logic error_multi,
    output logic [2:0] error_row
);
    initial begin
        error_line_n = 1'b1;
        error_multi = 1'b0;
        error_row = 3'h0;
    end
    // Row and kind mean nothing outside a report, so they go inverted when idle.
    task automatic report(input logic multi, input logic [2:0] row);
        error_line_n <= 1'b0;
        error_multi <= multi;
        error_row <= row;
        @(posedge clk);
        error_line_n <= 1'b1;
        error_multi <= ~multi;
        error_row <= ~row;
    endtask
endmodule

// File: test/testbench.sv
/*
 * Self-checking bench of the host controller.
 * Assumes APB answers before the watchdog expires and shortened reset timers.
 */
`timescale 1ns/10ps
module testbench;
    import hdc_pkg::*;
    localparam int PROC_N = 40;
    localparam int PCI_N = 20;
    typedef struct {logic [11:0] ra; logic [31:0] rv; logic [35:0] a; logic [2:0] c;
        logic [2:0] e;} hdc_step_t;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ta = 0, perr_n = 1, pdet = 0;
    logic pready, pslverr, err, ln, lm, soe, poe, crq_n, prs_n, ini_n, fl_n, stall;
    logic [2:0] lr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    hdc_cpu_req_t req = '0;
    hdc_route_t route;
    hdc_pci_req_t preq = '0;
    logic pcl, sout, pout;
    int failures = 0, n_tests = 0, cnt[3];
    always #5 clk = ~clk;
    hdc_host_ctl #(.PROC_RST_CYCLES(PROC_N), .PCI_RST_CYCLES(PCI_N)) dut (.clk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_req(req),
        .cpu_route(route), .pci_req(preq), .pci_claim(pcl), .target_abort_rcvd(ta),
        .pci_perr_n_in(perr_n), .pci_parity_detect(pdet), .companion_error_line_n(ln),
        .companion_error_multi(lm), .companion_error_row(lr), .pci_serr_n_out(sout),
        .pci_serr_n_oe(soe), .pci_perr_n_out(pout), .pci_perr_n_oe(poe),
        .processor_reset_request_n(crq_n), .pci_reset_output_n(prs_n),
        .processor_init_n(ini_n), .processor_flush_n(fl_n), .processor_stall(stall));
    hdc_companion_model peer (.clk, .error_line_n(ln), .error_multi(lm), .error_row(lr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Always one idle edge first, so a release and a new setup never share a time step.
    // Only the watchdog ends a wait for ready; no answer time is assumed here.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic t_regs;
        rdchk(A_ERR_EN, 32'h0);
        rdchk(A_ERR_STS, 32'h0);
        rdchk(A_RST_CTL, 32'h0);
        wr(A_ERR_EN, 32'hFF);
        rdchk(A_ERR_EN, 32'h1B);
        apb(1'b0, 12'h010, 32'h0);
        chk1(err, 1'b1);
    endtask
    task automatic t_bus;
        for (int e = 0; e < 2; e++) begin
            wr(A_ERR_EN, e ? 32'h1B : 32'h0);
            ta <= 1'b1;
            @(posedge clk);
            ta <= 1'b0;
            perr_n <= 1'b0;
            @(posedge clk);
            perr_n <= 1'b1;
            chk1(soe, e[0]);
            @(posedge clk);
            chk1(soe, e[0]);
        end
        pdet <= 1'b1;
        @(posedge clk);
        pdet <= 1'b0;
        @(posedge clk);
        chk1(poe, 1'b1);
    endtask
    task automatic err_case(input logic m, input logic [2:0] r, input logic s);
        peer.report(m, r);
        @(posedge clk);
        chk1(soe, s);
    endtask
    task automatic t_err;
        err_case(1'b1, 3'h5, 1'b1);
        err_case(1'b1, 3'h2, 1'b0);
        rdchk(A_ERR_STS, 32'hB0);
        wr(A_ERR_STS, 32'h0);
        rdchk(A_ERR_STS, 32'hB0);
        wr(A_ERR_STS, 32'h10);
        rdchk(A_ERR_STS, 32'hA0);
        err_case(1'b0, 3'h3, 1'b1);
        err_case(1'b0, 3'h6, 1'b1);
        rdchk(A_ERR_STS, 32'hA7);
        wr(A_ERR_STS, 32'h1);
        rdchk(A_ERR_STS, 32'hA6);
        wr(A_PCI_CMD, 32'h0);
        err_case(1'b0, 3'h1, 1'b0);
        wr(A_PCI_CMD, 32'h3);
    endtask
    task automatic t_rst;
        logic [7:0] pre[5] = '{8'h02, 8'h0A, 8'h00, 8'h08, 8'h0C};
        int ex[5][3] = '{'{PROC_N, PCI_N, 0}, '{PROC_N, PCI_N, PROC_N + INIT_HOLD_CYC},
            '{0, 0, SOFT_INIT_CYC}, '{0, 0, SOFT_INIT_CYC}, '{0, 0, 0}};
        for (int i = 0; i < 5; i++) begin
            wr(A_RST_CTL, {24'h0, pre[i]});
            wr(A_RST_CTL, {24'h0, pre[i] | 8'h04});
            cnt = '{0, 0, 0};
            repeat (100) begin
                @(posedge clk);
                cnt[0] += int'(crq_n === 1'b0);
                cnt[1] += int'(prs_n === 1'b0);
                cnt[2] += int'(ini_n === 1'b0);
            end
            chk(cnt[0], ex[i][0]);
            chk(cnt[1], ex[i][1]);
            chk(cnt[2], ex[i][2]);
        end
    endtask
    task automatic t_slow;
        wr(A_SLOW_CNT, 32'h80);
        wr(A_RST_CTL, 32'hF1);
        rdchk(A_RST_CTL, 32'h1);
        cnt = '{0, 0, 0};
        repeat (256) begin
            @(posedge clk);
            cnt[0] += int'(stall === 1'b1);
            cnt[1] += int'(fl_n === 1'b0);
        end
        chk(cnt[0], 128);
        chk(cnt[1], 256);
        wr(A_RST_CTL, 32'h0);
        repeat (2) @(posedge clk);
        chk1(fl_n, 1'b1);
    endtask
    task automatic t_dec;
        hdc_step_t tb[17] = '{
            '{12'h0, 32'h0, 36'h7FFFF, 3'h0, 3'h4},
            '{A_HOLE, 32'h40, 36'h80000, 3'h0, 3'h2},
            '{A_HOLE, 32'h0, 36'h9FFFF, 3'h0, 3'h4},
            '{12'h0, 32'h0, 36'hA0000, 3'h1, 3'h2},
            '{A_WINDOW, 32'h0A, 36'hA0000, 3'h1, 3'h4},
            '{A_WINDOW, 32'h2A, 36'hA0000, 3'h1, 3'h2},
            '{12'h0, 32'h0, 36'hA0000, 3'h3, 3'h4},
            '{A_WINDOW, 32'h4A, 36'hBFFFF, 3'h0, 3'h4},
            '{A_WINDOW, 32'h5A, 36'hA0000, 3'h0, 3'h2},
            '{A_ATTR, 32'h1, 36'hC0000, 3'h0, 3'h4},
            '{12'h0, 32'h0, 36'hC0000, 3'h4, 3'h2},
            '{12'h0, 32'h0, 36'hC4000, 3'h0, 3'h2},
            '{12'h0, 32'h0, 36'hF0000, 3'h0, 3'h2},
            '{A_TOP_DRAM, 32'h4, 36'hF00000, 3'h0, 3'h4},
            '{A_HOLE, 32'h80, 36'hF00000, 3'h0, 3'h2},
            '{12'h0, 32'h0, 36'h2000000, 3'h0, 3'h2},
            '{12'h0, 32'h0, 36'h100000000, 3'h4, 3'h1}};
        foreach (tb[i]) begin
            if (tb[i].ra != 12'h0) wr(tb[i].ra, tb[i].rv);
            @(posedge clk);
            req <= '{1'b1, tb[i].a, tb[i].c[2], tb[i].c[1], tb[i].c[0]};
            @(posedge clk);
            req.valid <= 1'b0;
            @(posedge clk);
            chk({28'h0, route}, {29'h1, tb[i].e});
        end
        wr(A_WINDOW, 32'h4A);
        rdchk(A_WINDOW, 32'h1A);
    endtask
    // Runs after the decode table: high hole selected, top of DRAM at 32 MB.
    task automatic t_pci;
        logic [31:0] pa[3] = '{32'h00F00000, 32'h00200000, 32'h000A0000};
        logic ex[3] = '{1'b0, 1'b1, 1'b0};
        foreach (pa[i]) begin
            @(posedge clk);
            preq <= '{1'b1, pa[i]};
            @(posedge clk);
            preq.valid <= 1'b0;
            @(posedge clk);
            chk1(pcl, ex[i]);
        end
        chk1(sout, 1'b0);
        chk1(pout, 1'b0);
    endtask
    initial begin
        #200us;
        failures++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        wr(A_PCI_CMD, 32'h3);
        t_bus();
        t_err();
        t_rst();
        t_slow();
        t_dec();
        t_pci();
        stop_test();
    end
endmodule
